//--- hdl/lscp_consts.vh
// constants for the serial configuration port of the panel controller
`ifndef LSCP_CONSTS_VH
`define LSCP_CONSTS_VH

// command codes following the start bit
`define LSCP_CMD_READ      3'h0
`define LSCP_CMD_WRITE     3'h1

// bit counts, as last index of a field
`define LSCP_CMD_LAST      3'h2
`define LSCP_BYTE_LAST     3'h7
`define LSCP_CNT_ZERO      3'h0
`define LSCP_CNT_ONE       3'h1

// register indices and reset values
`define LSCP_CTRL_IDX      8'h02
`define LSCP_AUX_IDX       8'h03
`define LSCP_CTRL_RST      8'h00
`define LSCP_PANEL_EN_BIT  6

// pattern memory window inside the 256 byte map
`define LSCP_PAT_LO        8'h40
`define LSCP_PAT_HI        8'hff

// value returned for pattern reads while the panel is enabled
`define LSCP_LOCKED_RD     8'h00
`define LSCP_BYTE_ZERO     8'h00

// input synchroniser lanes
`define LSCP_SYNC_W        4
`define LSCP_LANE_SCLK     0
`define LSCP_LANE_SEL      1
`define LSCP_LANE_SERIAL_DATA_IN     2
`define LSCP_LANE_PWR      3

`endif

//--- hdl/lscp_sync.v
// two flip-flop synchroniser for the asynchronous pins of the port
`timescale 1ns/1ps
`include "lscp_consts.vh"

module lscp_sync #(
  parameter W = `LSCP_SYNC_W
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

//--- hdl/lscp_serial_port.v
// serial configuration port with control register and panel enable lock
`timescale 1ns/1ps
`include "lscp_consts.vh"

module lscp_serial_port (
  input  wire       core_clk_i,
  input  wire       nrst_i,
  input  wire       ce_i,
  input  wire       sclk_i,
  input  wire       serial_select_i,
  input  wire       serial_data_in_i,
  input  wire       panel_power_request_in_i,
  output reg        serial_data_out_o,
  output reg        serial_data_out_oe_o,
  output reg        panel_on_o,
  output reg        panel_output_enable_o
);

  // ****************************************************************
  // states of the frame sequencer
  // ****************************************************************
  localparam ST_IDLE  = 3'b000;
  localparam ST_CMD   = 3'b001;
  localparam ST_ADDR  = 3'b010;
  localparam ST_TURN  = 3'b011;
  localparam ST_RDATA = 3'b100;
  localparam ST_WDATA = 3'b101;
  localparam ST_WIDLE = 3'b110;
  localparam ST_END   = 3'b111;

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg                    rst_meta;
  reg                    rst_n;
  wire [`LSCP_SYNC_W-1:0] pins_q;
  reg                    sclk_prev;
  reg  [2:0]             state;
  reg  [2:0]             cnt;
  reg  [2:0]             cmd;
  reg  [7:0]             addr;
  reg  [7:0]             shreg;
  reg  [7:0]             ctrl;
  reg  [7:0]             mem [0:255];
  reg  [7:0]             rd_byte;
  wire                   sclk_s;
  wire                   sel_s;
  wire                   serial_data_in_s;
  wire                   pwr_s;
  wire                   sclk_rise;
  wire                   bit_take;
  wire                   wr_fire;
  wire [7:0]             wr_byte;
  wire                   locked;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // address falls in the pattern memory window
  function is_pattern;
    input [7:0] a;
    begin
      is_pattern = (a >= `LSCP_PAT_LO) && (a <= `LSCP_PAT_HI);
    end
  endfunction

  // location still writable while the panel is enabled
  function lock_exempt;
    input [7:0] a;
    begin
      lock_exempt = (a == `LSCP_CTRL_IDX) || (a == `LSCP_AUX_IDX);
    end
  endfunction

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  // asynchronous assert, two flop release
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // all link pins cross through the same two stages
  lscp_sync #(
    .W (`LSCP_SYNC_W)
  ) u_sync (
    .clk_i  (core_clk_i),
    .nrst_i (rst_n),
    .ce_i   (ce_i),
    .d_i    ({panel_power_request_in_i, serial_data_in_i,
              serial_select_i, sclk_i}),
    .q_o    (pins_q)
  );

  assign sclk_s = pins_q[`LSCP_LANE_SCLK];
  assign sel_s  = pins_q[`LSCP_LANE_SEL];
  assign serial_data_in_s = pins_q[`LSCP_LANE_SERIAL_DATA_IN];
  assign pwr_s  = pins_q[`LSCP_LANE_PWR];

  // rising edge of the serial clock, seen after synchronisation
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else if (ce_i) begin
      sclk_prev <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev;
  // select and data sampled together on the rising edge
  assign bit_take  = sclk_rise & sel_s;
  assign locked    = ctrl[`LSCP_PANEL_EN_BIT];

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  // one byte per frame, dropped select returns to idle
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= `LSCP_CNT_ZERO;
      cmd   <= 3'h0;
      addr  <= `LSCP_BYTE_ZERO;
      shreg <= `LSCP_BYTE_ZERO;
    end else if (ce_i && sclk_rise) begin
      if (!sel_s) begin
        state <= ST_IDLE;
        cnt   <= `LSCP_CNT_ZERO;
      end else begin
        case (state)
          ST_IDLE: begin
            if (serial_data_in_s) begin
              state <= ST_CMD;
              cnt   <= `LSCP_CNT_ZERO;
            end
          end
          ST_CMD: begin
            cmd <= {cmd[1:0], serial_data_in_s};
            if (cnt == `LSCP_CMD_LAST) begin
              cnt <= `LSCP_CNT_ZERO;
              if (({cmd[1:0], serial_data_in_s} == `LSCP_CMD_READ) ||
                  ({cmd[1:0], serial_data_in_s} == `LSCP_CMD_WRITE)) begin
                state <= ST_ADDR;
              end else begin
                state <= ST_END;
              end
            end else begin
              cnt <= cnt + `LSCP_CNT_ONE;
            end
          end
          ST_ADDR: begin
            addr <= {addr[6:0], serial_data_in_s};
            if (cnt == `LSCP_BYTE_LAST) begin
              cnt   <= `LSCP_CNT_ZERO;
              state <= (cmd == `LSCP_CMD_WRITE) ? ST_WDATA : ST_TURN;
            end else begin
              cnt <= cnt + `LSCP_CNT_ONE;
            end
          end
          ST_TURN: begin
            // idle bit over, load the byte to send
            shreg <= {rd_byte[6:0], 1'b0};
            state <= ST_RDATA;
          end
          ST_RDATA: begin
            shreg <= {shreg[6:0], 1'b0};
            if (cnt == `LSCP_BYTE_LAST) begin
              cnt   <= `LSCP_CNT_ZERO;
              state <= ST_END;
            end else begin
              cnt <= cnt + `LSCP_CNT_ONE;
            end
          end
          ST_WDATA: begin
            shreg <= {shreg[6:0], serial_data_in_s};
            if (cnt == `LSCP_BYTE_LAST) begin
              cnt   <= `LSCP_CNT_ZERO;
              state <= ST_WIDLE;
            end else begin
              cnt <= cnt + `LSCP_CNT_ONE;
            end
          end
          ST_WIDLE: begin
            state <= ST_END;
          end
          ST_END: begin
            state <= ST_END; // wait for select to drop
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // read data path
  // ****************************************************************
  // control from its own register, locked pattern reads give filler
  always @* begin
    if (addr == `LSCP_CTRL_IDX) begin
      rd_byte = ctrl;
    end else if (locked && is_pattern(addr)) begin
      rd_byte = `LSCP_LOCKED_RD;
    end else begin
      rd_byte = mem[addr];
    end
  end

  // output changes only on rising edges, driven for the eight data bits
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out_o    <= 1'b0;
      serial_data_out_oe_o <= 1'b0;
    end else if (ce_i && sclk_rise) begin
      if (sel_s && state == ST_TURN) begin
        serial_data_out_o    <= rd_byte[7];
        serial_data_out_oe_o <= 1'b1;
      end else if (sel_s && state == ST_RDATA && cnt != `LSCP_BYTE_LAST) begin
        serial_data_out_o    <= shreg[7];
        serial_data_out_oe_o <= 1'b1;
      end else begin
        serial_data_out_o    <= 1'b0;
        serial_data_out_oe_o <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // write path and lock
  // ****************************************************************
  assign wr_fire = bit_take && (state == ST_WDATA) && (cnt == `LSCP_BYTE_LAST);
  assign wr_byte = {shreg[6:0], serial_data_in_s};

  // control register stays writable in every mode
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `LSCP_CTRL_RST;
    end else if (ce_i && wr_fire && addr == `LSCP_CTRL_IDX) begin
      ctrl <= wr_byte;
    end
  end

  // other locations except the aux register frozen while the panel is enabled
  always @(posedge core_clk_i) begin
    if (ce_i && wr_fire && addr != `LSCP_CTRL_IDX) begin
      if (!locked || lock_exempt(addr)) begin
        mem[addr] <= wr_byte;
      end
    end
  end

  // ****************************************************************
  // panel enable outputs
  // ****************************************************************
  // power request only matters once the enable bit is set
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      panel_on_o            <= 1'b0;
      panel_output_enable_o <= 1'b0;
    end else if (ce_i) begin
      panel_on_o            <= locked & pwr_s;
      panel_output_enable_o <= locked;
    end
  end

endmodule

//--- sim/lscp_port_sva.sv
// assertion checker for the serial configuration port
`timescale 1ns/1ps
module lscp_port_sva (
  input logic core_clk_i,
  input logic nrst_i,
  input logic ce_i,
  input logic sclk_i,
  input logic serial_select_i,
  input logic serial_data_in_i,
  input logic panel_power_request_in_i,
  input logic serial_data_out_o,
  input logic serial_data_out_oe_o,
  input logic panel_on_o,
  input logic panel_output_enable_o
);
  int oe_cnt;
  // length of the current read-data drive
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      oe_cnt <= 0;
    else if (serial_data_out_oe_o)
      oe_cnt <= oe_cnt + 1;
    else
      oe_cnt <= 0;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_out_idle_zero: assert property (!serial_data_out_oe_o |-> !serial_data_out_o)
    else $error("output not low while released");
  a_oe_in_frame: assert property (serial_data_out_oe_o |-> $past(serial_select_i, 2))
    else $error("output driven outside a frame");
  a_oe_eight_bits: assert property ($fell(serial_data_out_oe_o) |-> oe_cnt == 64)
    else $error("read drive not eight bit periods");
  a_dout_on_rise: assert property ($changed(serial_data_out_o) |-> $past(sclk_i, 2))
    else $error("output changed away from a rising serial clock");
  a_on_needs_en: assert property (panel_on_o |-> panel_output_enable_o)
    else $error("panel on without enable bit");
  a_on_follows: assert property
    ((panel_output_enable_o && panel_power_request_in_i) [*6] |=> panel_on_o)
    else $error("panel stays off with enable and request");
  a_off_no_req: assert property (!panel_power_request_in_i [*6] |=> !panel_on_o)
    else $error("panel on without power request");
  a_en_in_frame: assert property
    ($changed(panel_output_enable_o) |-> $past(serial_select_i, 4))
    else $error("enable bit changed outside a frame");
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst_i |-> !panel_output_enable_o && !panel_on_o && !serial_data_out_oe_o)
    else $error("outputs active in reset");
endmodule

//--- sim/lscp_host.sv
// host model driving the serial configuration link
`timescale 1ns/1ps
module lscp_host (
  input  logic core_clk_i,
  input  logic sdout_i,
  output logic sclk_o,
  output logic sel_o,
  output logic serial_data_in_o
);
  // link idle, clock stands still low
  initial begin
    sclk_o = 1'b0;
    sel_o = 1'b0;
    serial_data_in_o = 1'b0;
  end
  // one frame of nbits bit periods; shorter counts abort it
  task automatic xfer(input logic [2:0] cmd, input logic [7:0] addr,
                      input logic [7:0] wd, input int nbits, output logic [7:0] rd);
    logic [20:0] f;
    f = (cmd == 3'h1) ? {1'b1, cmd, addr, wd, 1'b0} : {1'b1, cmd, addr, 9'h000};
    rd = 8'h00;
    for (int i = 20; i > 20 - nbits; i--) begin
      @(posedge core_clk_i);
      sclk_o <= 1'b0;
      sel_o <= 1'b1;
      serial_data_in_o <= f[i];
      repeat (4) @(posedge core_clk_i);
      if (i <= 7)
        rd[i] = sdout_i;
      sclk_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    sclk_o <= 1'b0;
    sel_o <= 1'b0;
    serial_data_in_o <= ~f[21-nbits];
    // one full serial clock with select low closes the frame
    repeat (4) @(posedge core_clk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sclk_o <= 1'b0;
    repeat (16) @(posedge core_clk_i);
  endtask
endmodule

//--- sim/lscp_serial_port_tb.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
module lscp_serial_port_tb;
  logic core_clk_i;
  logic nrst_i;
  logic pwr;
  logic sclk;
  logic sel;
  logic serial_data_in;
  logic [7:0] rd;
  wire  sdout;
  wire  sdout_oe;
  wire  panel_on;
  wire  panel_en;
  wire  sdout_bus;
  logic ce;
  // released output line reads high, the inverse of the low sdout
  assign sdout_bus = sdout_oe ? sdout : ~sdout;
  int   n_mismatch;
  int   checks;
  lscp_serial_port DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .sclk_i(sclk), .serial_select_i(sel), .serial_data_in_i(serial_data_in),
    .panel_power_request_in_i(pwr), .serial_data_out_o(sdout),
    .serial_data_out_oe_o(sdout_oe), .panel_on_o(panel_on), .panel_output_enable_o(panel_en));
  lscp_host host (.core_clk_i(core_clk_i), .sdout_i(sdout_bus), .sclk_o(sclk), .sel_o(sel),
    .serial_data_in_o(serial_data_in));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(3'h1, a, d, 21, rd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.xfer(3'h0, a, 8'h00, 21, rd);
    chk(rd, e);
  endtask
  task automatic t_reset();
    chk({5'h00, sdout_oe, panel_on, panel_en}, 8'h00);
    rdchk(8'h02, 8'h00);
  endtask
  task automatic t_access();
    logic [7:0] a [4] = '{8'h03, 8'h10, 8'h40, 8'hff};
    logic [7:0] d [4] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3};
    for (int i = 0; i < 4; i++)
      wr(a[i], d[i]);
    for (int i = 0; i < 4; i++)
      rdchk(a[i], d[i]);
  endtask
  task automatic t_bad_cmd();
    for (int c = 2; c < 8; c++)
      host.xfer(c[2:0], 8'h10, 8'hff, 21, rd);
    rdchk(8'h10, 8'h3c);
  endtask
  task automatic t_abort();
    host.xfer(3'h1, 8'h10, 8'h00, 16, rd);
    rdchk(8'h10, 8'h3c);
  endtask
  task automatic t_lock();
    @(posedge core_clk_i);
    pwr <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk({7'h00, panel_on}, 8'h00);
    wr(8'h02, 8'h40);
    chk({7'h00, panel_en}, 8'h01);
    chk({7'h00, panel_on}, 8'h01);
    pwr <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    chk({7'h00, panel_on}, 8'h00);
    wr(8'h10, 8'h00);
    rdchk(8'h10, 8'h3c);
    wr(8'h03, 8'h77);
    rdchk(8'h03, 8'h77);
    wr(8'h40, 8'h11);
    rdchk(8'h40, 8'h00);
    rdchk(8'h02, 8'h40);
    wr(8'h02, 8'h00);
    chk({7'h00, panel_en}, 8'h00);
    wr(8'h10, 8'h99);
    rdchk(8'h10, 8'h99);
    rdchk(8'h40, 8'h5a);
  endtask
  // frame sent while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge core_clk_i);
    ce <= 1'b0;
    wr(8'h10, 8'h55);
    ce <= 1'b1;
    rdchk(8'h10, 8'h99);
  endtask
  // main sequence after a twelve cycle reset
  initial begin
    n_mismatch = 0;
    checks = 0;
    nrst_i = 1'b0;
    pwr = 1'b0;
    ce = 1'b1;
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    t_reset();
    t_access();
    t_bad_cmd();
    t_abort();
    t_lock();
    t_freeze();
    print_verdict();
  end
  // watchdog cuts a hung run short
  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_mismatch++;
    print_verdict();
  end
endmodule
bind lscp_serial_port lscp_port_sva u_sva (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .ce_i(ce_i), .sclk_i(sclk_i), .serial_select_i(serial_select_i),
  .serial_data_in_i(serial_data_in_i), .panel_power_request_in_i(panel_power_request_in_i),
  .serial_data_out_o(serial_data_out_o), .serial_data_out_oe_o(serial_data_out_oe_o),
  .panel_on_o(panel_on_o), .panel_output_enable_o(panel_output_enable_o));
